/* File: isra_pkg.sv */
package isra_pkg;

   // Bus framing
   localparam logic [3:0] ISRA_BYTE_BITS = 4'h8;
   localparam logic [2:0] ISRA_ADDR_FIXED = 3'h3;
   localparam logic ISRA_DIR_WRITE = 1'b0;

   // Register map
   localparam logic [7:0] ISRA_ADDR_CFG_A = 8'h7D;
   localparam logic [7:0] ISRA_ADDR_CFG_RST = 8'h60;
   localparam int ISRA_CFG_FIELD_HI = 7;
   localparam int ISRA_CFG_FIELD_LO = 4;
   localparam logic [3:0] ISRA_CFG_RSVD = 4'h0;
   localparam logic [7:0] ISRA_STATUS_CFG_A = 8'h01;
   localparam logic [7:0] ISRA_SHADOW_LO_A = 8'h60;
   localparam logic [7:0] ISRA_SHADOW_HI_A = 8'h7F;
   localparam logic [7:0] ISRA_AUTO_WR_LAST_A = 8'h4F;
   localparam logic [7:0] ISRA_FUNCTION_COMMAND_BYTE_A = 8'hFE;
   localparam logic [7:0] ISRA_PAST_END_DATA = 8'hFF;

   // Timing: the local clock must oversample the fastest bus clock
   localparam int ISRA_CLK_KHZ = 10000;
   localparam int ISRA_BUS_MAX_KHZ = 400;
   localparam int ISRA_MIN_OVERSAMPLE = 16;

   typedef enum logic [3:0] {
      ISRA_IDLE,
      ISRA_ADDR,
      ISRA_ADDR_ACK,
      ISRA_PTR,
      ISRA_PTR_ACK,
      ISRA_WDATA,
      ISRA_WDATA_ACK,
      ISRA_RDATA,
      ISRA_RDATA_ACK
   } isra_state_t;

   // Locations the bus master may change: status/config and the shadow block
   function automatic logic isra_writable(input logic [7:0] a);
      isra_writable = (a == ISRA_STATUS_CFG_A) || (a >= ISRA_SHADOW_LO_A && a <= ISRA_SHADOW_HI_A);
   endfunction

endpackage

/* File: isra_line_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module isra_line_sync #(
   parameter int STAGES = 2
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o,
   output logic scl_rise_o,
   output logic scl_fall_o,
   output logic start_o,
   output logic stop_o
);

   if (STAGES < 2) begin : g_chk
      $error("isra_line_sync needs at least two stages");
   end

   logic [STAGES:0] scl_reg;
   logic [STAGES:0] sda_reg;

   // Lines idle high, so reset to the idle level to avoid a false edge
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         scl_reg <= '1;
         sda_reg <= '1;
      end else begin
         scl_reg <= {scl_reg[STAGES-1:0], scl_i};
         sda_reg <= {sda_reg[STAGES-1:0], sda_i};
      end
   end

   assign scl_o = scl_reg[STAGES-1];
   assign sda_o = sda_reg[STAGES-1];
   assign scl_rise_o = scl_reg[STAGES-1] & ~scl_reg[STAGES];
   assign scl_fall_o = ~scl_reg[STAGES-1] & scl_reg[STAGES];
   assign start_o = scl_reg[STAGES-1] & scl_reg[STAGES] & sda_reg[STAGES] & ~sda_reg[STAGES-1];
   assign stop_o = scl_reg[STAGES-1] & scl_reg[STAGES] & ~sda_reg[STAGES] & sda_reg[STAGES-1];

endmodule
`default_nettype wire

/* File: isra_mem.sv */
`timescale 1ns/1ns
`default_nettype none
module isra_mem #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wr_en_i,
   input wire logic [AW-1:0] wr_addr_i,
   input wire logic [DW-1:0] wr_data_i,
   input wire logic [AW-1:0] rd_a_addr_i,
   output logic [DW-1:0] rd_a_data_o,
   input wire logic [AW-1:0] rd_b_addr_i,
   output logic [DW-1:0] rd_b_data_o
);

   if (AW < 1 || DW < 1) begin : g_chk
      $error("isra_mem needs nonzero widths");
   end

   logic [DW-1:0] mem_reg [0:(1<<AW)-1];

   always_ff @(posedge clk_i) begin
      if (wr_en_i) begin
         mem_reg[wr_addr_i] <= wr_data_i;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_a_data_o <= '0;
         rd_b_data_o <= '0;
      end else begin
         rd_a_data_o <= mem_reg[rd_a_addr_i];
         rd_b_data_o <= mem_reg[rd_b_addr_i];
      end
   end

endmodule
`default_nettype wire

/* File: isra_core.sv */
`timescale 1ns/1ns
`default_nettype none
module isra_core
   import isra_pkg::*;
#(
   parameter int SYNC_STAGES = 2
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic [6:0] target_address_o,
   output logic addressed_o,
   output logic cmd_wr_o,
   output logic [7:0] cmd_data_o,
   input wire logic core_wr_i,
   input wire logic [7:0] core_addr_i,
   input wire logic [7:0] core_data_i,
   output logic core_ready_o,
   output logic [7:0] core_rd_data_o
);

   // The bus rate is never configured; only the oversampling margin matters
   if (ISRA_CLK_KHZ < ISRA_MIN_OVERSAMPLE * ISRA_BUS_MAX_KHZ) begin : g_rate_chk
      $error("local clock too slow for the fastest bus clock");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Line conditioning

   logic scl_q;
   logic sda_q;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;

   isra_line_sync #(
      .STAGES(SYNC_STAGES)
   ) i_isra_line_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .scl_o(scl_q),
      .sda_o(sda_q),
      .scl_rise_o(scl_rise),
      .scl_fall_o(scl_fall),
      .start_o(bus_start),
      .stop_o(bus_stop)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // State and decode

   isra_state_t state_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] rx_reg;
   logic dir_read_reg;
   logic master_ack_reg;
   logic [8:0] ptr_reg;
   logic autoinc_reg;
   logic overrun_reg;
   logic [7:0] tx_reg;
   logic drive_low_reg;
   logic [7:0] bus_address_config_reg;
   logic cmd_wr_reg;
   logic [7:0] cmd_data_reg;

   logic [7:0] mem_rdata;
   logic [7:0] byte_out;
   logic rx_state;
   logic rx_done;
   logic addr_hit;
   logic wr_discard;
   logic wr_take;
   logic cmd_take;
   logic tx_last;
   logic mem_wr_en;
   logic [7:0] mem_wr_addr;
   logic [7:0] mem_wr_data;

   assign rx_state = (state_reg == ISRA_ADDR) || (state_reg == ISRA_PTR) || (state_reg == ISRA_WDATA);
   assign rx_done = scl_fall && rx_state && (bit_cnt_reg == ISRA_BYTE_BITS);
   assign addr_hit = rx_reg[7:1] ==
      {ISRA_ADDR_FIXED, bus_address_config_reg[ISRA_CFG_FIELD_HI:ISRA_CFG_FIELD_LO]};
   assign tx_last = bit_cnt_reg == (ISRA_BYTE_BITS - 4'h1);

   // Discard anything past the end, past the auto-increment ceiling, or not writable
   assign wr_discard = ptr_reg[8] || overrun_reg || !isra_writable(ptr_reg[7:0]);
   // Only a byte complete at its eighth bit is stored, as its acknowledge begins
   assign wr_take = rx_done && (state_reg == ISRA_WDATA) && !wr_discard;
   // A direct write to the function command byte is passed on; an auto-incremented one is not
   assign cmd_take = rx_done && (state_reg == ISRA_WDATA) && !autoinc_reg && !ptr_reg[8]
      && (ptr_reg[7:0] == ISRA_FUNCTION_COMMAND_BYTE_A);

   // Past FFh the pointer sits at 100h and the answer is fixed
   always_comb begin
      if (ptr_reg[8]) begin
         byte_out = ISRA_PAST_END_DATA;
      end else if (ptr_reg[7:0] == ISRA_ADDR_CFG_A) begin
         byte_out = bus_address_config_reg;
      end else begin
         byte_out = mem_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Transaction sequencing

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= ISRA_IDLE;
         bit_cnt_reg <= 4'h0;
         rx_reg <= 8'h00;
         dir_read_reg <= 1'b0;
         master_ack_reg <= 1'b0;
      end else if (bus_start) begin
         state_reg <= ISRA_ADDR;
         bit_cnt_reg <= 4'h0;
      end else if (bus_stop) begin
         state_reg <= ISRA_IDLE;
         bit_cnt_reg <= 4'h0;
      end else begin
         if (scl_rise && rx_state) begin
            rx_reg <= {rx_reg[6:0], sda_q};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
         end
         if (scl_rise && state_reg == ISRA_RDATA_ACK) begin
            master_ack_reg <= ~sda_q;
         end
         unique case (state_reg)
            ISRA_IDLE: begin
            end
            ISRA_ADDR: begin
               if (rx_done) begin
                  bit_cnt_reg <= 4'h0;
                  dir_read_reg <= rx_reg[0] != ISRA_DIR_WRITE;
                  // A foreign address leaves us deaf until the next START
                  state_reg <= addr_hit ? ISRA_ADDR_ACK : ISRA_IDLE;
               end
            end
            ISRA_ADDR_ACK: begin
               if (scl_fall) begin
                  state_reg <= dir_read_reg ? ISRA_RDATA : ISRA_PTR;
               end
            end
            ISRA_PTR: begin
               if (rx_done) begin
                  bit_cnt_reg <= 4'h0;
                  state_reg <= ISRA_PTR_ACK;
               end
            end
            ISRA_PTR_ACK: begin
               if (scl_fall) begin
                  state_reg <= ISRA_WDATA;
               end
            end
            ISRA_WDATA: begin
               if (rx_done) begin
                  bit_cnt_reg <= 4'h0;
                  state_reg <= ISRA_WDATA_ACK;
               end
            end
            ISRA_WDATA_ACK: begin
               // Stays in the write until the master's STOP or repeated START
               if (scl_fall) begin
                  state_reg <= ISRA_WDATA;
               end
            end
            ISRA_RDATA: begin
               if (scl_fall) begin
                  bit_cnt_reg <= tx_last ? 4'h0 : bit_cnt_reg + 4'h1;
                  if (tx_last) begin
                     state_reg <= ISRA_RDATA_ACK;
                  end
               end
            end
            ISRA_RDATA_ACK: begin
               if (scl_fall) begin
                  state_reg <= master_ack_reg ? ISRA_RDATA : ISRA_IDLE;
               end
            end
            default: begin
               state_reg <= ISRA_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Memory pointer

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ptr_reg <= 9'h000;
         autoinc_reg <= 1'b0;
         overrun_reg <= 1'b0;
      end else if (!bus_start && !bus_stop) begin
         if (rx_done && state_reg == ISRA_PTR) begin
            ptr_reg <= {1'b0, rx_reg};
            autoinc_reg <= 1'b0;
            overrun_reg <= 1'b0;
         end else if (rx_done && state_reg == ISRA_WDATA) begin
            autoinc_reg <= 1'b1;
            if (!ptr_reg[8] && ptr_reg[7:0] == ISRA_AUTO_WR_LAST_A) begin
               overrun_reg <= 1'b1;
            end
            if (!ptr_reg[8]) begin
               ptr_reg <= ptr_reg + 9'h001;
            end
         end else if (scl_fall && state_reg == ISRA_RDATA && tx_last && !ptr_reg[8]) begin
            ptr_reg <= ptr_reg + 9'h001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Data line drive

   // Only ever pulls low; the high level comes from the pull-up
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_reg <= 8'h00;
         drive_low_reg <= 1'b0;
      end else if (bus_start || bus_stop) begin
         drive_low_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            ISRA_ADDR: begin
               if (rx_done && addr_hit) begin
                  drive_low_reg <= 1'b1;
               end
            end
            ISRA_PTR, ISRA_WDATA: begin
               // Discarded bytes are still acknowledged so the stream keeps its framing
               if (rx_done) begin
                  drive_low_reg <= 1'b1;
               end
            end
            ISRA_ADDR_ACK: begin
               if (scl_fall) begin
                  if (dir_read_reg) begin
                     tx_reg <= byte_out;
                     drive_low_reg <= ~byte_out[7];
                  end else begin
                     drive_low_reg <= 1'b0;
                  end
               end
            end
            ISRA_PTR_ACK, ISRA_WDATA_ACK: begin
               if (scl_fall) begin
                  drive_low_reg <= 1'b0;
               end
            end
            ISRA_RDATA: begin
               if (scl_fall) begin
                  if (tx_last) begin
                     drive_low_reg <= 1'b0;
                  end else begin
                     tx_reg <= {tx_reg[6:0], 1'b0};
                     drive_low_reg <= ~tx_reg[6];
                  end
               end
            end
            ISRA_RDATA_ACK: begin
               if (scl_fall) begin
                  if (master_ack_reg) begin
                     tx_reg <= byte_out;
                     drive_low_reg <= ~byte_out[7];
                  end else begin
                     drive_low_reg <= 1'b0;
                  end
               end
            end
            ISRA_IDLE: begin
               drive_low_reg <= 1'b0;
            end
            default: begin
               drive_low_reg <= 1'b0;
            end
         endcase
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe_o = drive_low_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Address configuration and command hand-off

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         bus_address_config_reg <= ISRA_ADDR_CFG_RST;
      end else if (wr_take && ptr_reg[7:0] == ISRA_ADDR_CFG_A) begin
         bus_address_config_reg <= {rx_reg[ISRA_CFG_FIELD_HI:ISRA_CFG_FIELD_LO], ISRA_CFG_RSVD};
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cmd_wr_reg <= 1'b0;
         cmd_data_reg <= 8'h00;
      end else begin
         cmd_wr_reg <= cmd_take;
         if (cmd_take) begin
            cmd_data_reg <= rx_reg;
         end
      end
   end

   assign target_address_o = {ISRA_ADDR_FIXED, bus_address_config_reg[ISRA_CFG_FIELD_HI:ISRA_CFG_FIELD_LO]};
   assign addressed_o = (state_reg != ISRA_IDLE) && (state_reg != ISRA_ADDR);
   assign cmd_wr_o = cmd_wr_reg;
   assign cmd_data_o = cmd_data_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Shadow memory

   // Bus writes win; the gauge core retries when ready is low
   assign core_ready_o = !wr_take;
   assign mem_wr_en = wr_take || core_wr_i;
   assign mem_wr_addr = wr_take ? ptr_reg[7:0] : core_addr_i;
   assign mem_wr_data = wr_take ? rx_reg : core_data_i;

   isra_mem #(
      .AW(8),
      .DW(8)
   ) i_isra_mem (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_en_i(mem_wr_en),
      .wr_addr_i(mem_wr_addr),
      .wr_data_i(mem_wr_data),
      .rd_a_addr_i(ptr_reg[7:0]),
      .rd_a_data_o(mem_rdata),
      .rd_b_addr_i(core_addr_i),
      .rd_b_data_o(core_rd_data_o)
   );

endmodule
`default_nettype wire

/* File: isra_core_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module isra_core_monitor
   import isra_pkg::*;
#(
   parameter int SYNC_STAGES = 2
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic [6:0] target_address_o,
   input wire logic addressed_o,
   input wire logic cmd_wr_o,
   input wire logic [7:0] cmd_data_o,
   input wire logic core_wr_i,
   input wire logic [7:0] core_addr_i,
   input wire logic [7:0] core_data_i,
   input wire logic core_ready_o,
   input wire logic [7:0] core_rd_data_o
);
   logic [2:0] scl_q;
   logic [2:0] sda_q;
   logic bus_cond;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         scl_q <= 3'h7;
         sda_q <= 3'h7;
      end else begin
         scl_q <= {scl_q[1:0], scl_i};
         sda_q <= {sda_q[1:0], sda_i};
      end
   end
   // Data moving while the clock stays high is a START or a STOP
   assign bus_cond = scl_q[1] && scl_q[2] && (sda_q[1] != sda_q[2]);
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_open_drain_low: assert property (sda_oe_o |-> !sda_o)
      else $error("data line driven high");
   a_fixed_addr_bits: assert property (target_address_o[6:4] == ISRA_ADDR_FIXED)
      else $error("fixed address bits wrong");
   a_cfg_by_bus: assert property ($changed(target_address_o) |-> addressed_o || $past(addressed_o))
      else $error("address changed outside a transaction");
   a_drive_clock_low: assert property ($changed(sda_oe_o) |-> !scl_i)
      else $error("data drive changed while clock high");
   a_stop_to_idle: assert property (bus_cond && sda_q[1] |-> ##[1:4] (!addressed_o && !sda_oe_o))
      else $error("stop did not return to idle");
   a_start_listens: assert property (bus_cond && !sda_q[1] |-> ##[1:4] !sda_oe_o)
      else $error("data line held after start");
   a_cmd_one_pulse: assert property (cmd_wr_o |=> !cmd_wr_o)
      else $error("command strobe too long");
   a_cmd_data_hold: assert property ($changed(cmd_data_o) |-> cmd_wr_o)
      else $error("command byte changed without strobe");
   a_store_in_txn: assert property (!core_ready_o |-> addressed_o)
      else $error("store outside a transaction");
endmodule
bind isra_core isra_core_monitor #(.SYNC_STAGES(SYNC_STAGES)) i_isra_core_monitor (
   .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
   .target_address_o(target_address_o), .addressed_o(addressed_o), .cmd_wr_o(cmd_wr_o),
   .cmd_data_o(cmd_data_o), .core_wr_i(core_wr_i), .core_addr_i(core_addr_i), .core_data_i(core_data_i),
   .core_ready_o(core_ready_o), .core_rd_data_o(core_rd_data_o));
`default_nettype wire

/* File: isra_bus_master.sv */
`timescale 1ns/1ns
`default_nettype none
module isra_bus_master (
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_oe_o
);
   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end
   // Two local clocks a quarter bit give an 800 ns bus clock; the answer lands within three clocks of a fall
   task automatic q(input int n);
      repeat (2 * n) @(negedge clk_i);
   endtask
   task automatic bit_io(input logic b, output logic r);
      sda_oe_o = ~b;
      q(1);
      scl_o = 1'b1;
      q(1);
      r = sda_i;
      q(1);
      scl_o = 1'b0;
      q(1);
   endtask
   task automatic start_cond();
      sda_oe_o = 1'b0;
      q(1);
      scl_o = 1'b1;
      q(1);
      sda_oe_o = 1'b1;
      q(1);
      scl_o = 1'b0;
      q(1);
   endtask
   task automatic stop_cond();
      sda_oe_o = 1'b1;
      q(1);
      scl_o = 1'b1;
      q(1);
      sda_oe_o = 1'b0;
      q(2);
   endtask
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   task automatic rd_byte(input logic ack_o, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(~ack_o, r);
   endtask
endmodule
`default_nettype wire

/* File: test_isra_core.sv */
`timescale 1ns/1ns
`default_nettype none
module test_isra_core;
   import isra_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic scl, m_oe, sda_o, sda_oe, addressed, cmd_wr, core_ready;
   logic core_wr = 1'b0;
   logic [7:0] core_addr = 8'h00;
   logic [7:0] core_data = 8'h00;
   logic [7:0] core_rd, cmd_data;
   logic [6:0] tgt;
   int error_cnt = 0;
   int comparisons = 0;
   int cmd_cnt = 0;
   // Open-drain wire with pull-up
   wire logic sda = ~(m_oe | (sda_oe & ~sda_o));
   always #50 clk = ~clk;
   always @(posedge clk) if (cmd_wr === 1'b1) cmd_cnt++;
   isra_core i_isra_core (.clk_i(clk), .rst_i(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
      .target_address_o(tgt), .addressed_o(addressed), .cmd_wr_o(cmd_wr), .cmd_data_o(cmd_data),
      .core_wr_i(core_wr), .core_addr_i(core_addr), .core_data_i(core_data), .core_ready_o(core_ready),
      .core_rd_data_o(core_rd));
   isra_bus_master i_isra_bus_master (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic send(input logic [7:0] b, input logic exp_ack);
      logic ack;
      i_isra_bus_master.wr_byte(b, ack);
      chk({7'h0, ack}, {7'h0, exp_ack}, "acknowledge");
   endtask
   task automatic bus_write(input logic [7:0] wa, input logic [7:0] ptr, input logic [7:0] d[$]);
      i_isra_bus_master.start_cond();
      send(wa, 1'b1);
      send(ptr, 1'b1);
      foreach (d[i]) send(d[i], 1'b1);
      i_isra_bus_master.stop_cond();
   endtask
   task automatic bus_read(input logic [7:0] wa, input logic [7:0] ptr, input logic [7:0] e[$]);
      logic [7:0] got;
      i_isra_bus_master.start_cond();
      send(wa, 1'b1);
      send(ptr, 1'b1);
      i_isra_bus_master.start_cond();
      send(wa | 8'h01, 1'b1);
      foreach (e[i]) begin
         i_isra_bus_master.rd_byte(i + 1 < e.size(), got);
         chk(got, e[i], "read data");
      end
      chk({7'h0, sda_oe}, 8'h00, "released after nak");
      i_isra_bus_master.stop_cond();
   endtask
   task automatic core_write(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk);
      core_addr = a;
      core_data = v;
      core_wr = 1'b1;
      @(negedge clk);
      core_wr = 1'b0;
   endtask
   task automatic core_check(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      core_addr = a;
      repeat (2) @(negedge clk);
      chk(core_rd, e, "stored byte");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk({1'b0, tgt}, 8'h36, "reset address");
      chk({7'h0, sda_oe}, 8'h00, "reset drive");
      chk({7'h0, addressed}, 8'h00, "reset addressed");
      chk({7'h0, core_ready}, 8'h01, "reset ready");
      $display("test reset done");
   endtask
   task automatic t_probe();
      logic [7:0] wrong[3] = '{8'h6E, 8'hEC, 8'h2C};
      i_isra_bus_master.start_cond();
      send(8'h6C, 1'b1);
      i_isra_bus_master.stop_cond();
      foreach (wrong[i]) begin
         i_isra_bus_master.start_cond();
         send(wrong[i], 1'b0);
         send(8'h00, 1'b0);
         chk({7'h0, addressed}, 8'h00, "foreign address");
         i_isra_bus_master.stop_cond();
      end
      $display("test probe done");
   endtask
   task automatic t_write_read();
      logic r;
      bus_write(8'h6C, 8'h60, '{8'hA5, 8'h3C, 8'h0F});
      bus_read(8'h6C, 8'h60, '{8'hA5, 8'h3C, 8'h0F});
      core_check(8'h61, 8'h3C);
      // Half a byte then STOP must leave the location alone
      i_isra_bus_master.start_cond();
      send(8'h6C, 1'b1);
      send(8'h60, 1'b1);
      for (int i = 0; i < 4; i++) i_isra_bus_master.bit_io(1'b0, r);
      i_isra_bus_master.stop_cond();
      core_check(8'h60, 8'hA5);
      $display("test write read done");
   endtask
   task automatic t_discard();
      core_write(8'h02, 8'h11);
      core_write(8'h80, 8'h33);
      core_write(8'h50, 8'h44);
      bus_write(8'h6C, 8'h4F, '{8'h01, 8'h02});
      bus_write(8'h6C, 8'h02, '{8'h55});
      bus_write(8'h6C, 8'h7F, '{8'h9A, 8'hBC});
      core_check(8'h02, 8'h11);
      core_check(8'h80, 8'h33);
      core_check(8'h7F, 8'h9A);
      core_check(8'h50, 8'h44);
      $display("test discard done");
   endtask
   task automatic t_past_end();
      core_write(8'hFF, 8'h5A);
      bus_read(8'h6C, 8'hFF, '{8'h5A, 8'hFF, 8'hFF});
      $display("test past end done");
   endtask
   task automatic t_command();
      bus_write(8'h6C, 8'hFE, '{8'h81});
      chk(cmd_cnt[7:0], 8'h01, "command strobes");
      chk(cmd_data, 8'h81, "command byte");
      bus_write(8'h6C, 8'hFD, '{8'h00, 8'h42});
      chk(cmd_cnt[7:0], 8'h01, "command strobes");
      chk(cmd_data, 8'h81, "command byte");
      $display("test command done");
   endtask
   task automatic t_addr_cfg();
      bus_write(8'h6C, ISRA_ADDR_CFG_A, '{8'hA7});
      chk({1'b0, tgt}, 8'h3A, "new address");
      i_isra_bus_master.start_cond();
      send(8'h6C, 1'b0);
      i_isra_bus_master.stop_cond();
      bus_read(8'h74, ISRA_ADDR_CFG_A, '{8'hA0});
      bus_write(8'h74, ISRA_ADDR_CFG_A, '{8'h60});
      chk({1'b0, tgt}, 8'h36, "default address");
      $display("test address config done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      t_reset();
      t_probe();
      t_write_read();
      t_discard();
      t_past_end();
      t_command();
      t_addr_cfg();
      finish_test();
   end
   initial begin
      // About 4300 clocks of traffic are expected; over four times that means a hang
      repeat (20000) @(posedge clk);
      error_cnt++;
      finish_test();
   end
endmodule
`default_nettype wire
